// file: ext_bus_pkg.sv
// Package with constants and carrier types for the external bus unit.
package ext_bus_pkg;

	localparam int unsigned ADDR_W      = 19;
	localparam int unsigned DATA_W      = 16;
	localparam int unsigned ZONE_W      = 3;
	localparam int unsigned PHASE_W     = 4;
	localparam int unsigned NUM_ZONES   = 8;

	// Zone numbers that own a chip select.
	localparam logic [2:0] ZONE_0       = 3'h0;
	localparam logic [2:0] ZONE_1       = 3'h1;
	localparam logic [2:0] ZONE_2       = 3'h2;
	localparam logic [2:0] ZONE_6       = 3'h6;
	localparam logic [2:0] ZONE_7       = 3'h7;

	// Reset values of the timing configuration fields.
	localparam logic [3:0] LEAD_RST     = 4'h3;
	localparam logic [3:0] ACTIVE_RST   = 4'h7;
	localparam logic [3:0] TRAIL_RST    = 4'h3;
	localparam logic       USE_RDY_RST  = 1'b1;
	localparam logic       RDY_ASYNC_RST = 1'b1;

	// Per-zone timing: phase lengths in clock cycles plus ready options.
	typedef struct packed {
		logic [3:0] rd_lead;
		logic [3:0] rd_active;
		logic [3:0] rd_trail;
		logic [3:0] wr_lead;
		logic [3:0] wr_active;
		logic [3:0] wr_trail;
		logic       use_ready;
		logic       ready_async;
	} zone_timing_config_s;

	// One access request from the internal side.
	typedef struct packed {
		logic [2:0]  zone;
		logic [18:0] addr;
		logic        write;
		logic [15:0] wdata;
	} bus_req_s;

	// External pins of the bus, output enables low while driving.
	typedef struct packed {
		logic [18:0] ext_address_bus;
		logic [15:0] ext_data_bus_out;
		logic        addr_oe_n;
		logic        data_oe_n;
		logic        strobe_oe_n;
		logic        zone_low_pair_select_n;
		logic        zone_two_select_n;
		logic        zone_high_pair_select_n;
		logic        ext_write_strobe_n;
		logic        ext_read_strobe_n;
		logic        ext_read_not_write;
	} bus_pins_s;

endpackage

// file: ext_periph_model.sv
// Memory-like peripheral that answers the external bus unit.
`timescale 1ns/1ps
module ext_periph_model
	import ext_bus_pkg::*;
(
	input  wire logic                   clk_sys_i,   // System clock.
	input  wire ext_bus_pkg::bus_pins_s pins_i,      // Bus pins from the unit.
	input  wire logic [3:0]             rdy_delay_i, // Strobe cycles before ready.
	output logic [15:0]                 data_o,      // Level on the data pins.
	output logic                        ready_o      // Ready pin.
);
	logic [15:0] mem [16];
	logic [3:0]  cnt_q;
	logic        strb;

	assign strb = !pins_i.strobe_oe_n && (!pins_i.ext_read_strobe_n || !pins_i.ext_write_strobe_n);
	assign ready_o = strb && (cnt_q >= rdy_delay_i);

	// The peripheral drives only while read is strobed; when neither side drives, the pull-ups win.
	always_comb begin
		if (!pins_i.data_oe_n) begin
			data_o = pins_i.ext_data_bus_out;
		end else if (strb && !pins_i.ext_read_strobe_n) begin
			data_o = mem[pins_i.ext_address_bus[3:0]];
		end else begin
			data_o = 16'hffff;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (strb && !pins_i.data_oe_n && !pins_i.ext_write_strobe_n) begin
			mem[pins_i.ext_address_bus[3:0]] <= pins_i.ext_data_bus_out;
		end
		cnt_q <= strb ? cnt_q + 4'h1 : 4'h0;
	end
endmodule

// file: external_bus_unit.sv
// External parallel bus master: zone decode, strobe timing, ready and hold handshake.
`timescale 1ns/1ps
// Behaviour
// - Drive 19-bit address output, releasable to high impedance.
// - 16-bit bidirectional data bus, tristatable, pulled up weakly outside.
// - Mode select high maps zone 7 externally; low removes it.
// - Mode select captured into config bit at reset; software may rewrite.
// - Hold request releases bus after current access and no pending ones.
// - Hold grant goes low only with all outputs already released.
// - Grant removed after request removed; only then drive bus again.
// - Shared select low for accesses to zone 0 or 1.
// - Dedicated select low for accesses to zone 2.
// - Shared select low for accesses to zone 6 or 7.
// - Write strobe active low with per-zone lead, active, trail.
// - Read strobe active low with per-zone lead, active, trail.
// - Read and write strobes never low together.
// - Read-not-write idles high, low during writes.
// - Ready high completes access; synchronous or asynchronous by configuration.
module external_bus_unit
	import ext_bus_pkg::*;
#(
	parameter int unsigned AW = ext_bus_pkg::ADDR_W,  // Address width.
	parameter int unsigned DW = ext_bus_pkg::DATA_W   // Data width.
) (
	input  wire logic                            clk_sys_i,            // System clock, 50 MHz.
	input  wire logic                            rst_n_i,              // Synchronous reset, active low.
	input  wire logic                            clk_en_i,             // Clock enable, freezes all state when low.
	input  wire ext_bus_pkg::bus_req_s           req_i,                // Access request.
	input  wire logic                            req_valid_i,          // Request pending.
	output logic                                 req_ready_o,          // Request taken at the previous edge, one-cycle pulse.
	output logic                                 done_o,               // Access finished, one-cycle pulse.
	output logic [ext_bus_pkg::DATA_W-1:0]       rdata_o,              // Read data, valid with done_o.
	output logic                                 zone_err_o,           // Request to an unmapped zone, pulse.
	input  wire ext_bus_pkg::zone_timing_config_s zone_timing_config_i [ext_bus_pkg::NUM_ZONES], // Per-zone timing.
	input  wire logic                            mode_wr_i,            // Software write strobe for zone 7 bit.
	input  wire logic                            mode_wdata_i,         // Value written to zone 7 bit.
	output logic                                 upper_zone_en_o,      // Zone 7 mapped externally.
	input  wire logic                            upper_zone_mode_select_i, // Mode select pin.
	input  wire logic                            bus_hold_request_n_i, // Hold request, active low.
	output logic                                 bus_hold_grant_n_o,   // Hold grant, active low.
	output logic                                 bus_hold_grant_oe_n_o, // Grant pin enable, low drives.
	input  wire logic                            ext_ready_in_i,       // Ready from peripheral.
	input  wire logic [ext_bus_pkg::DATA_W-1:0]  ext_data_bus_i,       // Data pins input.
	output ext_bus_pkg::bus_pins_s               pins_o                // Bus pin outputs and enables.
);
	import ext_bus_pkg::*;

	// ************************************************************
	// Sequencer state
	// ************************************************************
	typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_ACTIVE, ST_TRAIL, ST_HOLD} bus_state_e;

	bus_state_e          state_q;
	bus_state_e          state_d;
	logic [PHASE_W-1:0]  cnt_q;
	logic [PHASE_W-1:0]  cnt_d;
	bus_req_s            cur_q;
	bus_req_s            cur_d;
	bus_pins_s           pins_q;
	bus_pins_s           pins_d;
	logic [DW-1:0]       rdata_q;
	logic [DW-1:0]       rdata_d;
	logic                done_q;
	logic                done_d;
	logic                acc_q;
	logic                acc_d;
	logic                zerr_q;
	logic                zerr_d;
	logic                grant_n_q;
	logic                grant_n_d;
	logic                up_en_q;
	logic                up_en_d;
	logic                strap_pend_q;
	logic                strap_pend_d;
	logic                ready_s;

	zone_timing_config_s tcfg;
	logic                zone_ok;

	assign tcfg = zone_timing_config_i[cur_q.zone];

	ready_sync u_ready_sync (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.clk_en_i  (clk_en_i),
		.async_i   (tcfg.ready_async),
		.ready_i   (ext_ready_in_i),
		.ready_o   (ready_s)
	);

	// Only zones with a chip select exist externally; zone 7 also needs the mode bit.
	always_comb begin
		case (req_i.zone)
			ZONE_0, ZONE_1, ZONE_2, ZONE_6: zone_ok = 1'b1;
			ZONE_7:                         zone_ok = up_en_q;
			default:                        zone_ok = 1'b0;
		endcase
	end

	// ************************************************************
	// Chip-select decode of the incoming request
	// ************************************************************
	logic                sel_low_n;
	logic                sel_two_n;
	logic                sel_high_n;

	// Decoded straight from the request so the selects settle in the same cycle as the address.
	always_comb begin
		sel_low_n  = !(req_i.zone == ZONE_0 || req_i.zone == ZONE_1);
		sel_two_n  = !(req_i.zone == ZONE_2);
		sel_high_n = !(req_i.zone == ZONE_6 || req_i.zone == ZONE_7);
	end

	// ************************************************************
	// Phase lengths of the access in flight
	// ************************************************************
	logic [PHASE_W-1:0]  lead_len;
	logic [PHASE_W-1:0]  act_len;
	logic [PHASE_W-1:0]  trail_len;
	logic [PHASE_W:0]    act_cnt1;

	always_comb begin
		lead_len  = cur_q.write ? tcfg.wr_lead : tcfg.rd_lead;
		act_len   = cur_q.write ? tcfg.wr_active : tcfg.rd_active;
		trail_len = cur_q.write ? tcfg.wr_trail : tcfg.rd_trail;
	end

	// One spare bit keeps a full-scale active length from wrapping while ready is awaited.
	assign act_cnt1 = {1'b0, cnt_q} + (PHASE_W+1)'(1);

	// ************************************************************
	// Configuration bit for zone 7
	// ************************************************************
	always_comb begin
		up_en_d      = up_en_q;
		strap_pend_d = strap_pend_q;
		if (clk_en_i) begin
			if (strap_pend_q) begin
				// The pin is caught on the first enabled cycle after reset, then never looked at again.
				up_en_d      = upper_zone_mode_select_i;
				strap_pend_d = 1'b0;
			end else if (mode_wr_i) begin
				up_en_d = mode_wdata_i;
			end
		end
	end

	// Kept apart from the sequencer so a held bus never delays a software write of the enable.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			up_en_q      <= 1'b0;
			strap_pend_q <= 1'b1;
		end else begin
			up_en_q      <= up_en_d;
			strap_pend_q <= strap_pend_d;
		end
	end

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		cur_d     = cur_q;
		pins_d    = pins_q;
		rdata_d   = rdata_q;
		done_d    = done_q;
		acc_d     = acc_q;
		zerr_d    = zerr_q;
		grant_n_d = grant_n_q;
		if (clk_en_i) begin
			// Pulses end only on an enabled edge, so a frozen clock enable stretches them instead of losing them.
			done_d = 1'b0;
			acc_d  = 1'b0;
			zerr_d = 1'b0;
			case (state_q)
				ST_IDLE: begin
					pins_d.zone_low_pair_select_n  = 1'b1;
					pins_d.zone_two_select_n       = 1'b1;
					pins_d.zone_high_pair_select_n = 1'b1;
					pins_d.ext_write_strobe_n      = 1'b1;
					pins_d.ext_read_strobe_n       = 1'b1;
					pins_d.ext_read_not_write      = 1'b1;
					pins_d.data_oe_n               = 1'b1;
					if (req_valid_i && !zone_ok) begin
						acc_d  = 1'b1;
						zerr_d = 1'b1;
					end else if (req_valid_i) begin
						acc_d                          = 1'b1;
						cur_d                          = req_i;
						pins_d.addr_oe_n               = 1'b0;
						pins_d.strobe_oe_n             = 1'b0;
						pins_d.ext_address_bus         = req_i.addr[AW-1:0];
						pins_d.zone_low_pair_select_n  = sel_low_n;
						pins_d.zone_two_select_n       = sel_two_n;
						pins_d.zone_high_pair_select_n = sel_high_n;
						pins_d.ext_read_not_write      = !req_i.write;
						pins_d.ext_data_bus_out        = req_i.wdata;
						pins_d.data_oe_n               = !req_i.write;
						cnt_d                          = '0;
						state_d                        = ST_LEAD;
					end else if (!bus_hold_request_n_i) begin
						// A waiting request is served first, so the bus is given away only when nothing is pending.
						pins_d.addr_oe_n   = 1'b1;
						pins_d.data_oe_n   = 1'b1;
						pins_d.strobe_oe_n = 1'b1;
						state_d            = ST_HOLD;
					end
				end
				ST_LEAD: begin
					cnt_d = cnt_q + 4'h1;
					if (cnt_d >= lead_len) begin
						cnt_d = '0;
						// Only one strobe is ever lowered, chosen by direction.
						pins_d.ext_write_strobe_n = !cur_q.write;
						pins_d.ext_read_strobe_n  = cur_q.write;
						state_d                   = ST_ACTIVE;
					end
				end
				ST_ACTIVE: begin
					if (cnt_q < act_len) begin
						cnt_d = cnt_q + 4'h1;
					end
					if (act_cnt1 >= {1'b0, act_len} && (!tcfg.use_ready || ready_s)) begin
						cnt_d                     = '0;
						rdata_d                   = cur_q.write ? rdata_q : ext_data_bus_i;
						pins_d.ext_write_strobe_n = 1'b1;
						pins_d.ext_read_strobe_n  = 1'b1;
						state_d                   = ST_TRAIL;
					end
				end
				ST_TRAIL: begin
					cnt_d = cnt_q + 4'h1;
					if (cnt_d >= trail_len) begin
						cnt_d   = '0;
						done_d  = 1'b1;
						state_d = ST_IDLE;
					end
				end
				ST_HOLD: begin
					// Grant goes low one cycle after the outputs were released.
					grant_n_d = bus_hold_request_n_i;
					if (bus_hold_request_n_i && !grant_n_q) begin
						grant_n_d = 1'b1;
					end else if (bus_hold_request_n_i && grant_n_q) begin
						// Drive again only after the grant has gone high.
						pins_d.addr_oe_n   = 1'b0;
						pins_d.strobe_oe_n = 1'b0;
						state_d            = ST_IDLE;
					end
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			state_q      <= ST_IDLE;
			cnt_q        <= '0;
			cur_q        <= '0;
			pins_q       <= '{ext_address_bus: '0, ext_data_bus_out: '0, addr_oe_n: 1'b0, data_oe_n: 1'b1,
			                  strobe_oe_n: 1'b0, zone_low_pair_select_n: 1'b1, zone_two_select_n: 1'b1,
			                  zone_high_pair_select_n: 1'b1, ext_write_strobe_n: 1'b1,
			                  ext_read_strobe_n: 1'b1, ext_read_not_write: 1'b1};
			rdata_q      <= '0;
			done_q       <= 1'b0;
			acc_q        <= 1'b0;
			zerr_q       <= 1'b0;
			grant_n_q    <= 1'b1;
		end else begin
			state_q      <= state_d;
			cnt_q        <= cnt_d;
			cur_q        <= cur_d;
			pins_q       <= pins_d;
			rdata_q      <= rdata_d;
			done_q       <= done_d;
			acc_q        <= acc_d;
			zerr_q       <= zerr_d;
			grant_n_q    <= grant_n_d;
		end
	end

	// The grant pin is never released, so its enable stays low.
	assign pins_o                = pins_q;
	assign rdata_o               = rdata_q;
	assign done_o                = done_q;
	assign req_ready_o           = acc_q;
	assign zone_err_o            = zerr_q;
	assign bus_hold_grant_n_o    = grant_n_q;
	assign bus_hold_grant_oe_n_o = 1'b0;
	assign upper_zone_en_o       = up_en_q;
endmodule

// file: external_bus_unit_props.sv
// Port-level assertions for the external bus unit.
`timescale 1ns/1ps
module external_bus_unit_props
	import ext_bus_pkg::*;
(
	input  wire logic                   clk_sys_i,            // System clock.
	input  wire logic                   rst_n_i,              // Reset, active low.
	input  wire ext_bus_pkg::bus_req_s  req_i,                // Request.
	input  wire logic                   req_ready_o,          // Request taken.
	input  wire logic                   done_o,               // Access done.
	input  wire logic                   zone_err_o,           // Bad zone.
	input  wire logic                   bus_hold_request_n_i, // Hold request.
	input  wire logic                   bus_hold_grant_n_o,   // Hold grant.
	input  wire ext_bus_pkg::bus_pins_s pins_o                // Bus pins.
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_acc(logic [2:0] a, logic [2:0] b);
		req_ready_o && !zone_err_o && ($past(req_i.zone) == a || $past(req_i.zone) == b);
	endsequence

	property p_excl; !(!pins_o.ext_read_strobe_n && !pins_o.ext_write_strobe_n); endproperty
	a_excl: assert property (p_excl) else $error("both strobes low");
	property p_wr_rnw; !pins_o.ext_write_strobe_n |-> !pins_o.ext_read_not_write; endproperty
	a_wr_rnw: assert property (p_wr_rnw) else $error("write without rnw low");
	property p_rd_rnw; !pins_o.ext_read_strobe_n |-> pins_o.ext_read_not_write && pins_o.data_oe_n; endproperty
	a_rd_rnw: assert property (p_rd_rnw) else $error("read with rnw low or data driven");
	property p_held; !bus_hold_grant_n_o |-> pins_o.addr_oe_n && pins_o.data_oe_n && pins_o.strobe_oe_n; endproperty
	a_held: assert property (p_held) else $error("pins driven while granted");
	property p_unhold;
		bus_hold_request_n_i && !bus_hold_grant_n_o |=> bus_hold_grant_n_o ##1 !pins_o.strobe_oe_n;
	endproperty
	a_unhold: assert property (p_unhold) else $error("grant not returned in time");
	property p_sel01; s_acc(ZONE_0, ZONE_1) |-> !pins_o.zone_low_pair_select_n
		&& pins_o.zone_two_select_n && pins_o.zone_high_pair_select_n; endproperty
	a_sel01: assert property (p_sel01) else $error("low pair select wrong");
	property p_sel2; s_acc(ZONE_2, ZONE_2) |-> !pins_o.zone_two_select_n
		&& pins_o.zone_low_pair_select_n && pins_o.zone_high_pair_select_n; endproperty
	a_sel2: assert property (p_sel2) else $error("zone two select wrong");
	property p_sel67; s_acc(ZONE_6, ZONE_7) |-> !pins_o.zone_high_pair_select_n
		&& pins_o.zone_low_pair_select_n && pins_o.zone_two_select_n; endproperty
	a_sel67: assert property (p_sel67) else $error("high pair select wrong");
	property p_err; zone_err_o |-> pins_o.zone_low_pair_select_n && pins_o.zone_two_select_n
		&& pins_o.zone_high_pair_select_n && pins_o.ext_read_strobe_n; endproperty
	a_err: assert property (p_err) else $error("bus activity on refused zone");
	property p_lead; req_ready_o |-> pins_o.ext_read_strobe_n && pins_o.ext_write_strobe_n; endproperty
	a_lead: assert property (p_lead) else $error("strobe without lead phase");
	property p_trail; done_o |-> $past(pins_o.ext_read_strobe_n) && $past(pins_o.ext_write_strobe_n); endproperty
	a_trail: assert property (p_trail) else $error("no trail phase before done");
endmodule

bind external_bus_unit external_bus_unit_props u_props (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
	.req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o), .zone_err_o(zone_err_o),
	.bus_hold_request_n_i(bus_hold_request_n_i), .bus_hold_grant_n_o(bus_hold_grant_n_o), .pins_o(pins_o));

// file: ready_sync.sv
// Two-stage synchroniser with a bypass for a ready input that is already synchronous.
`timescale 1ns/1ps
module ready_sync (
	input  wire logic clk_sys_i,    // System clock.
	input  wire logic rst_n_i,      // Synchronous reset, active low.
	input  wire logic clk_en_i,     // Clock enable.
	input  wire logic async_i,      // Take ready as asynchronous.
	input  wire logic ready_i,      // Raw ready pin.
	output logic      ready_o       // Ready as seen by the sequencer.
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	always_comb begin
		meta_d = meta_q;
		sync_d = sync_q;
		if (clk_en_i) begin
			meta_d = ready_i;
			sync_d = meta_q;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	// Asynchronous mode costs two cycles of latency but keeps metastability off the sequencer.
	assign ready_o = async_i ? sync_q : ready_i;
endmodule

// file: tb_external_bus_unit.sv
// Self-checking testbench for the external bus unit.
`timescale 1ns/1ps
module tb_external_bus_unit;
	import ext_bus_pkg::*;
	logic                clk_sys_i = 0, rst_n_i = 0, req_valid_i = 0, mode_wr_i = 0, mode_wdata_i = 0;
	logic                strap = 1, hold_n = 1, req_ready, done, zerr, uz_en, grant, rdy, grant_oe;
	bus_req_s            req_i = '0;
	zone_timing_config_s cfg [NUM_ZONES];
	bus_pins_s           pins;
	logic [15:0]         din, rdata;
	int                  err_count = 0, n_checks = 0, ticks = 0, c, l;
	logic                e;

	always #10 clk_sys_i = ~clk_sys_i;

	external_bus_unit dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .req_i(req_i),
		.req_valid_i(req_valid_i), .req_ready_o(req_ready), .done_o(done), .rdata_o(rdata), .zone_err_o(zerr),
		.zone_timing_config_i(cfg), .mode_wr_i(mode_wr_i), .mode_wdata_i(mode_wdata_i), .upper_zone_en_o(uz_en),
		.upper_zone_mode_select_i(strap), .bus_hold_request_n_i(hold_n), .bus_hold_grant_n_o(grant),
		.bus_hold_grant_oe_n_o(grant_oe), .ext_ready_in_i(rdy), .ext_data_bus_i(din), .pins_o(pins));
	ext_periph_model peer (.clk_sys_i(clk_sys_i), .pins_i(pins), .rdy_delay_i(4'h5), .data_o(din), .ready_o(rdy));

	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// The ceiling is far above the few hundred cycles the scenarios need.
	always @(posedge clk_sys_i) begin
		ticks++;
		if (ticks == 20000) begin
			err_count++;
			print_verdict();
		end
	end

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic acc(input logic [2:0] z, input logic w, input logic [15:0] d);
		@(posedge clk_sys_i);
		req_i <= '{zone: z, addr: 19'h00100 | 19'(z), write: w, wdata: d};
		req_valid_i <= 1'b1;
		// The unit is idle, so the request is taken at the next edge and must not be offered again.
		@(posedge clk_sys_i);
		req_valid_i <= 1'b0;
		@(negedge clk_sys_i);
		chk("request taken", req_ready, 1);
		e = zerr;
		if (!e) chk("address", pins.ext_address_bus, 19'h00100 | 19'(z));
		c = 1;
		l = 0;
		while (!e && c < 60) begin
			@(negedge clk_sys_i);
			if (done === 1'b1) break;
			c++;
			if ((w ? pins.ext_write_strobe_n : pins.ext_read_strobe_n) === 1'b0) l++;
		end
		if (!e) chk("access done", done, 1);
	endtask

	task t_zones;
		logic [2:0] zl [5];
		zl = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
		foreach (zl[i]) begin
			acc(zl[i], 1'b1, 16'ha5c0 + 16'(zl[i]));
			if (!cfg[zl[i]].use_ready) chk("write length", c, 6);
			if (!cfg[zl[i]].use_ready) chk("write active", l, 3);
			acc(zl[i], 1'b0, 16'h0);
			chk("read data", rdata, 16'ha5c0 + 16'(zl[i]));
			if (!cfg[zl[i]].use_ready) chk("read length", c, cfg[zl[i]].rd_lead + 3 + zl[i][0]);
			chk("read active", (cfg[zl[i]].use_ready ? l > 4 : l == 2 + zl[i][0]), 1);
		end
	endtask

	task t_mode(input logic v);
		@(posedge clk_sys_i);
		mode_wr_i <= 1'b1;
		mode_wdata_i <= v;
		@(posedge clk_sys_i);
		mode_wr_i <= 1'b0;
		@(negedge clk_sys_i);
		chk("zone 7 enable", uz_en, v);
		acc(3'h7, 1'b0, 16'h0);
		chk("zone 7 refused", e, !v);
	endtask

	task t_hold;
		fork
			acc(3'h2, 1'b1, 16'h1234);
			begin
				// Hold is raised in the same cycle as the request, which must still be served first.
				@(posedge clk_sys_i);
				hold_n <= 1'b0;
			end
		join
		chk("grant during access", grant, 1);
		chk("access completes", c, 6);
		repeat (4) @(negedge clk_sys_i);
		chk("grant", grant, 0);
		chk("grant pin driven", grant_oe, 0);
		chk("released", {pins.addr_oe_n, pins.data_oe_n, pins.strobe_oe_n}, 3'h7);
		@(posedge clk_sys_i);
		req_valid_i <= 1'b1;
		repeat (4) @(negedge clk_sys_i);
		chk("taken while held", req_ready, 0);
		@(posedge clk_sys_i);
		req_valid_i <= 1'b0;
		hold_n <= 1'b1;
		repeat (3) @(negedge clk_sys_i);
		chk("grant returned", grant, 1);
		acc(3'h2, 1'b0, 16'h0);
		chk("bus resumed", rdata, 16'h1234);
	endtask

	initial begin
		for (int z = 0; z < NUM_ZONES; z++) begin
			cfg[z] = '{4'(z % 4 + 1), 4'(2 + z % 2), 4'(1 + z / 4), 4'h2, 4'h3, 4'h1, z >= 6, z == 7};
		end
		repeat (20) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (3) @(negedge clk_sys_i);
		chk("idle pins", {pins.zone_low_pair_select_n, pins.zone_two_select_n, pins.zone_high_pair_select_n,
			pins.ext_read_strobe_n, pins.ext_write_strobe_n, pins.ext_read_not_write, pins.addr_oe_n}, 7'h7e);
		chk("strap high", uz_en, 1);
		@(posedge clk_sys_i);
		strap <= 1'b0;
		repeat (3) @(negedge clk_sys_i);
		chk("strap ignored", uz_en, 1);
		t_zones();
		acc(3'h4, 1'b1, 16'h0);
		chk("unmapped zone", e, 1);
		t_mode(1'b0);
		t_mode(1'b1);
		t_hold();
		@(posedge clk_sys_i);
		rst_n_i <= 1'b0;
		repeat (20) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (3) @(negedge clk_sys_i);
		chk("strap low at reset", uz_en, 0);
		print_verdict();
	end
endmodule
